// ---- design/pcc_loop_host.sv ----
/*
  host controller for a loop clock generator: takes settings and commands
  from software over axi4-lite and programs the device registers through a
  word-wide request/acknowledge port, in the documented order.
  assumes the device holds dev_ack_in for one cycle per accepted request.
*/
`timescale 1ns/100ps
`default_nettype none
module pcc_loop_host #(
  parameter logic [31:0] DEV_BASE    = 32'h0000_0000,
  parameter int          LOCK_CYCLES = pcc_pkg::LOCK_CYC
) (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic [4:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [4:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic             dev_req_out,
  output logic             dev_we_out,
  output logic [31:0]      dev_addr_out,
  output logic [31:0]      dev_wdata_out,
  input  wire logic        dev_ack_in,
  input  wire logic [31:0] dev_rdata_in
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  typedef struct packed {
    pcc_pkg::pcc_state_e st;
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0]  idx;
    logic        go_only;
    logic        enabled;
    logic        done;
    logic        err;
    logic [19:0] ref_khz;
    logic [4:0]  mult;
    logic [4:0]  d0;
    logic [4:0]  d1;
    logic [4:0]  d2;
    logic [4:0]  d3;
    logic        aw_got;
    logic        w_got;
    logic [4:0]  awaddr;
    logic [31:0] wbuf;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } pcc_host_s;

  pcc_host_s   s_r;
  pcc_host_s   s_nxt;
  logic        tmr_load;
  logic [14:0] tmr_count;
  logic        tmr_done;
  logic        cfg_ok;
  logic        fire;
  logic        wr;
  logic        rd;
  logic [31:0] wa;
  logic [31:0] wd;
  logic [4:0]  ratio;
  logic [31:0] m;
  logic        busy;

  // byte-lane merge of a write into an existing word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // settings check, done before any device write
  always_comb begin
    logic [31:0] ref32;
    logic [31:0] d0_32;
    logic [31:0] prod;
    ref32  = {12'h000, s_r.ref_khz};
    d0_32  = {27'h000_0000, s_r.d0};
    prod   = ref32 * {27'h000_0000, s_r.mult};
    cfg_ok = (s_r.d0 != '0) && (s_r.d1 != '0) && (s_r.d3 != '0)
      && (ref32 >= d0_32 * pcc_pkg::REF_MIN_KHZ)
      && (ref32 <= d0_32 * pcc_pkg::REF_MAX_KHZ)
      && (s_r.mult >= pcc_pkg::MULT_MIN)
      && (s_r.mult <= pcc_pkg::MULT_MAX)
      && (prod >= d0_32 * pcc_pkg::OUT_MIN_KHZ)
      && (prod <= d0_32 * pcc_pkg::OUT_MAX_KHZ)
      && ({2'b00, s_r.d2} == {1'b0, s_r.d1, 1'b0}
        || {2'b00, s_r.d2} == 7'(3 * s_r.d1)
        || {2'b00, s_r.d2} == {s_r.d1, 2'b00});
  end

  assign busy = (s_r.st != pcc_pkg::ST_IDLE);
  assign fire = s_r.req && dev_ack_in;

  // post-divider ratio for the divider being written
  always_comb begin
    case (s_r.idx)
      2'd1:    ratio = s_r.d1;
      2'd2:    ratio = s_r.d2;
      default: ratio = s_r.d3;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state: bus slave, sequencer and device request port
  always_comb begin
    pcc_pkg::pcc_state_e nxt;
    s_nxt     = s_r;
    nxt       = s_r.st;
    wr        = 1'b0;
    rd        = 1'b0;
    wa        = '0;
    wd        = '0;
    m         = '0;
    tmr_load  = 1'b0;
    tmr_count = '0;

    // address and data are taken independently, in either order
    if (s_axi_awvalid_in && !s_r.aw_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !s_r.w_got && !s_r.bvalid) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wbuf  = s_axi_wdata_in;
      s_nxt.wstrb = s_axi_wstrb_in;
    end
    // commit once both halves are in; settings are frozen while busy
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = pcc_pkg::RESP_OKAY;
      case (s_r.awaddr)
        pcc_pkg::REG_CTRL: begin
          if (!busy && s_r.wstrb[0] && (s_r.wbuf[0] || s_r.wbuf[1])) begin
            s_nxt.st      = pcc_pkg::ST_CHECK;
            s_nxt.go_only = !s_r.wbuf[0];
            s_nxt.done    = 1'b0;
            s_nxt.err     = 1'b0;
          end
        end
        pcc_pkg::REG_REF: begin
          m = merge({12'h000, s_r.ref_khz}, s_r.wbuf, s_r.wstrb);
          if (!busy) s_nxt.ref_khz = m[19:0];
        end
        pcc_pkg::REG_MULT: begin
          m = merge({27'h000_0000, s_r.mult}, s_r.wbuf, s_r.wstrb);
          if (!busy) s_nxt.mult = m[4:0];
        end
        pcc_pkg::REG_DIVS: begin
          m = merge({3'h0, s_r.d3, 3'h0, s_r.d2, 3'h0, s_r.d1,
                     3'h0, s_r.d0}, s_r.wbuf, s_r.wstrb);
          if (!busy) begin
            s_nxt.d0 = m[4:0];
            s_nxt.d1 = m[12:8];
            s_nxt.d2 = m[20:16];
            s_nxt.d3 = m[28:24];
          end
        end
        pcc_pkg::REG_STAT: ;
        default: s_nxt.bresp = pcc_pkg::RESP_SLVERR;
      endcase
    end
    if (s_r.bvalid && s_axi_bready_in) begin
      s_nxt.bvalid = 1'b0;
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
    end

    // reads answer one cycle after the address is taken
    if (s_axi_arvalid_in && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = pcc_pkg::RESP_OKAY;
      case (s_axi_araddr_in)
        pcc_pkg::REG_CTRL: s_nxt.rdata = '0;
        pcc_pkg::REG_REF:  s_nxt.rdata = {12'h000, s_r.ref_khz};
        pcc_pkg::REG_MULT: s_nxt.rdata = {27'h000_0000, s_r.mult};
        pcc_pkg::REG_DIVS: s_nxt.rdata = {3'h0, s_r.d3, 3'h0, s_r.d2,
                                          3'h0, s_r.d1, 3'h0, s_r.d0};
        pcc_pkg::REG_STAT: s_nxt.rdata = {24'h00_0000, s_r.st,
                                          s_r.enabled, s_r.err,
                                          s_r.done, busy};
        default: begin
          s_nxt.rdata = '0;
          s_nxt.rresp = pcc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_r.rvalid && s_axi_rready_in) begin
      s_nxt.rvalid = 1'b0;
    end

    // sequencer: each access state names one device access and its successor
    case (s_r.st)
      pcc_pkg::ST_IDLE: ;
      pcc_pkg::ST_CHECK: begin
        s_nxt.idx = 2'd1;
        if (!cfg_ok) begin
          s_nxt.err = 1'b1;
          s_nxt.st  = pcc_pkg::ST_IDLE;
        end else if (s_r.go_only) begin
          s_nxt.st = pcc_pkg::ST_POSTDIV;
        end else begin
          s_nxt.enabled = 1'b0;
          s_nxt.st      = pcc_pkg::ST_CSR_RST;
        end
      end
      pcc_pkg::ST_CSR_RST: begin
        // bypass first, loop in reset, before touching the loop
        wr = 1'b1;
        wa = pcc_pkg::DEV_CSR;
        wd[pcc_pkg::CSR_RST_BIT] = 1'b1;
        nxt = pcc_pkg::ST_WAIT_RST;
        tmr_load  = fire;
        tmr_count = 15'(pcc_pkg::RST_HOLD_CYC);
      end
      pcc_pkg::ST_WAIT_RST: begin
        if (tmr_done) s_nxt.st = pcc_pkg::ST_MULT;
      end
      pcc_pkg::ST_MULT: begin
        wr = 1'b1;
        wa = pcc_pkg::DEV_MULT;
        wd[4:0] = s_r.mult - 5'd1;
        nxt = pcc_pkg::ST_PREDIV;
      end
      pcc_pkg::ST_PREDIV: begin
        wr = 1'b1;
        wa = pcc_pkg::DEV_DIV0;
        wd[4:0] = s_r.d0 - 5'd1;
        wd[pcc_pkg::DIV_EN_BIT] = 1'b1;
        nxt = pcc_pkg::ST_CSR_RUN;
      end
      pcc_pkg::ST_CSR_RUN: begin
        // reset released, still bypassed
        wr  = 1'b1;
        wa  = pcc_pkg::DEV_CSR;
        nxt = pcc_pkg::ST_POSTDIV;
      end
      pcc_pkg::ST_POSTDIV: begin
        wr = 1'b1;
        wa = pcc_pkg::DEV_DIV0 + {28'h000_0000, s_r.idx, 2'b00};
        wd[4:0] = ratio - 5'd1;
        wd[pcc_pkg::DIV_EN_BIT] = 1'b1;
        nxt = (s_r.idx == 2'd3) ? pcc_pkg::ST_ALIGN
                                : pcc_pkg::ST_POSTDIV;
        if (fire) s_nxt.idx = s_r.idx + 2'd1;
      end
      pcc_pkg::ST_ALIGN: begin
        wr = 1'b1;
        wa = pcc_pkg::DEV_ALIGN;
        wd[2:0] = pcc_pkg::ALIGN_ALL;
        nxt = pcc_pkg::ST_GO;
      end
      pcc_pkg::ST_GO: begin
        wr = 1'b1;
        wa = pcc_pkg::DEV_CMD;
        wd[pcc_pkg::CMD_GO_BIT] = 1'b1;
        nxt = pcc_pkg::ST_POLL;
      end
      pcc_pkg::ST_POLL: begin
        // re-read until the device reports the divider change applied
        rd = 1'b1;
        wa = pcc_pkg::DEV_STAT;
        if (dev_rdata_in[pcc_pkg::STAT_BSY_BIT]) begin
          nxt = pcc_pkg::ST_POLL;
        end else if (s_r.go_only) begin
          nxt = pcc_pkg::ST_BR_ON;
        end else begin
          nxt = pcc_pkg::ST_WAIT_LK;
          tmr_load  = fire;
          tmr_count = 15'(LOCK_CYCLES);
        end
      end
      pcc_pkg::ST_WAIT_LK: begin
        if (tmr_done) s_nxt.st = pcc_pkg::ST_CSR_EN;
      end
      pcc_pkg::ST_CSR_EN: begin
        wr = 1'b1;
        wa = pcc_pkg::DEV_CSR;
        wd[pcc_pkg::CSR_EN_BIT] = 1'b1;
        nxt = pcc_pkg::ST_BR_ON;
        if (fire) s_nxt.enabled = 1'b1;
      end
      pcc_pkg::ST_BR_ON: begin
        wr = 1'b1;
        wa = pcc_pkg::DEV_BRIDGE;
        wd[pcc_pkg::BRG_RST_BIT] = 1'b1;
        nxt = pcc_pkg::ST_BR_OFF;
      end
      pcc_pkg::ST_BR_OFF: begin
        wr  = 1'b1;
        wa  = pcc_pkg::DEV_BRIDGE;
        nxt = pcc_pkg::ST_IDLE;
        if (fire) s_nxt.done = 1'b1;
      end
      default: s_nxt.st = pcc_pkg::ST_IDLE;
    endcase

    // one request in flight, held until acknowledged
    if (wr || rd) begin
      if (!s_r.req) begin
        s_nxt.req   = 1'b1;
        s_nxt.we    = wr;
        s_nxt.addr  = DEV_BASE + wa;
        s_nxt.wdata = wd;
      end else if (dev_ack_in) begin
        s_nxt.req = 1'b0;
        s_nxt.st  = nxt;
      end
    end
  end

  // settings reset to the device's own defaults
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s_r         <= '0;
      s_r.st      <= pcc_pkg::ST_IDLE;
      s_r.ref_khz <= pcc_pkg::REF_RST;
      s_r.mult    <= pcc_pkg::MULT_RST;
      s_r.d0      <= pcc_pkg::D0_RST;
      s_r.d1      <= pcc_pkg::D1_RST;
      s_r.d2      <= pcc_pkg::D2_RST;
      s_r.d3      <= pcc_pkg::D3_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  pcc_wait_timer #(.WIDTH(15)) u_timer (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .load_in  (tmr_load),
    .count_in (tmr_count),
    .done_out (tmr_done)
  );

  assign s_axi_awready_out = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready_out  = !s_r.w_got && !s_r.bvalid;
  assign s_axi_bvalid_out  = s_r.bvalid;
  assign s_axi_bresp_out   = s_r.bresp;
  assign s_axi_arready_out = !s_r.rvalid;
  assign s_axi_rvalid_out  = s_r.rvalid;
  assign s_axi_rdata_out   = s_r.rdata;
  assign s_axi_rresp_out   = s_r.rresp;
  assign dev_req_out       = s_r.req;
  assign dev_we_out        = s_r.we;
  assign dev_addr_out      = s_r.addr;
  assign dev_wdata_out     = s_r.wdata;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence br_assert;
    s_r.st == pcc_pkg::ST_BR_ON && fire;
  endsequence
  sequence br_release;
    s_r.st == pcc_pkg::ST_BR_OFF && !s_r.req
    ##1 s_r.req && s_r.wdata == '0
        && s_r.addr == DEV_BASE + pcc_pkg::DEV_BRIDGE;
  endsequence

  a_reset_hold_time: assert property (
    $rose(s_r.st == pcc_pkg::ST_MULT)
      |-> $past(s_r.st, 13) == pcc_pkg::ST_WAIT_RST)
    else $error("loop reset released too early");
  a_enable_after_lock: assert property (
    $rose(s_r.req) && s_r.st == pcc_pkg::ST_CSR_EN
      |-> $past(s_r.st, 2) == pcc_pkg::ST_WAIT_LK)
    else $error("enable written without lock wait");
  a_enable_checked: assert property (
    $rose(s_r.enabled) |-> cfg_ok && !s_r.err)
    else $error("loop enabled with settings out of range");
  a_mult_in_range: assert property (
    s_r.req && s_r.we && s_r.addr == DEV_BASE + pcc_pkg::DEV_MULT
      |-> s_r.wdata[4:0] >= 5'd3 && s_r.wdata[4:0] <= 5'd24)
    else $error("multiplier outside x4..x25");
  a_align_all_set: assert property (
    s_r.req && s_r.addr == DEV_BASE + pcc_pkg::DEV_ALIGN
      |-> s_r.wdata[2:0] == 3'h7)
    else $error("not all clocks aligned");
  a_go_after_div: assert property (
    $rose(s_r.req) && s_r.st == pcc_pkg::ST_GO
      |-> $past(s_r.st, 2) == pcc_pkg::ST_ALIGN)
    else $error("go command without divider writes");
  a_bridge_reset: assert property (
    br_assert |=> br_release)
    else $error("bridge reset not released next");
  a_start_disabled: assert property (
    s_r.st == pcc_pkg::ST_CSR_RST && s_r.req
      |-> !s_r.wdata[0] && s_r.wdata[1])
    else $error("setup began with loop enabled");
  a_req_stable: assert property (
    s_r.req && !dev_ack_in
      |=> s_r.req && $stable(s_r.addr) && $stable(s_r.wdata))
    else $error("device request changed before ack");
  a_bresp_both: assert property (
    $rose(s_r.bvalid) |-> $past(s_r.aw_got) && $past(s_r.w_got))
    else $error("write answered before both halves");
endmodule // pcc_loop_host
`default_nettype wire

// ---- design/pcc_wait_timer.sv ----
/*
  down-counting wait timer: loads a count, reports done at zero.
  assumes the caller loads it once per wait and polls done_out.
*/
`timescale 1ns/100ps
`default_nettype none
module pcc_wait_timer #(
  parameter int WIDTH = 15
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic             load_in,
  input  wire logic [WIDTH-1:0] count_in,
  output logic                  done_out
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } pcc_tmr_s;

  pcc_tmr_s s_r;
  pcc_tmr_s s_nxt;

  // load wins over counting so a fresh wait never ends early
  always_comb begin
    s_nxt = s_r;
    if (load_in) begin
      s_nxt.cnt = count_in;
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done_out = (s_r.cnt == '0);
endmodule // pcc_wait_timer
`default_nettype wire

// ---- shared/pcc_pkg.sv ----
/*
  constants, device register map and sequencer states for the host-side
  controller of a software-programmed loop clock generator.
  assumes a 100 MHz controller clock and a word-wide device register port.
*/
`default_nettype none
package pcc_pkg;
  // timing, least times rounded up to whole cycles
  localparam int CLK_NS       = 10;
  localparam int RST_HOLD_NS  = 125;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOCK_NS      = 187_500;
  localparam int LOCK_CYC     = (LOCK_NS + CLK_NS - 1) / CLK_NS;

  // frequency limits in kHz
  localparam logic [31:0] REF_MIN_KHZ = 32'd12_000;
  localparam logic [31:0] REF_MAX_KHZ = 32'd50_000;
  localparam logic [31:0] OUT_MIN_KHZ = 32'd140_000;
  localparam logic [31:0] OUT_MAX_KHZ = 32'd600_000;

  // multiplier and divider ratios and their reset values
  localparam logic [4:0] MULT_MIN = 5'd4;
  localparam logic [4:0] MULT_MAX = 5'd25;
  localparam logic [4:0] MULT_RST = 5'd13;
  localparam logic [4:0] D0_RST   = 5'd1;
  localparam logic [4:0] D1_RST   = 5'd1;
  localparam logic [4:0] D2_RST   = 5'd2;
  localparam logic [4:0] D3_RST   = 5'd3;
  localparam logic [19:0] REF_RST = 20'h0_5DC0;

  // device register offsets from the device base
  localparam logic [31:0] DEV_CSR    = 32'h0000_0100;
  localparam logic [31:0] DEV_MULT   = 32'h0000_0110;
  localparam logic [31:0] DEV_DIV0   = 32'h0000_0114;
  localparam logic [31:0] DEV_CMD    = 32'h0000_0138;
  localparam logic [31:0] DEV_STAT   = 32'h0000_013C;
  localparam logic [31:0] DEV_ALIGN  = 32'h0000_0140;
  localparam logic [31:0] DEV_BRIDGE = 32'h0000_0024;
  localparam int CSR_EN_BIT   = 0;
  localparam int CSR_RST_BIT  = 1;
  localparam int DIV_EN_BIT   = 15;
  localparam int CMD_GO_BIT   = 0;
  localparam int STAT_BSY_BIT = 0;
  localparam int BRG_RST_BIT  = 0;
  localparam logic [2:0] ALIGN_ALL = 3'h7;

  // software register offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_REF  = 5'h04;
  localparam logic [4:0] REG_MULT = 5'h08;
  localparam logic [4:0] REG_DIVS = 5'h0C;
  localparam logic [4:0] REG_STAT = 5'h10;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_CHECK   = 4'b0001,
    ST_CSR_RST = 4'b0010,
    ST_WAIT_RST= 4'b0011,
    ST_MULT    = 4'b0100,
    ST_PREDIV  = 4'b0101,
    ST_CSR_RUN = 4'b0110,
    ST_POSTDIV = 4'b0111,
    ST_ALIGN   = 4'b1000,
    ST_GO      = 4'b1001,
    ST_POLL    = 4'b1010,
    ST_WAIT_LK = 4'b1011,
    ST_CSR_EN  = 4'b1100,
    ST_BR_ON   = 4'b1101,
    ST_BR_OFF  = 4'b1110
  } pcc_state_e;
endpackage
`default_nettype wire

// ---- testbench/pcc_dev_model.sv ----
/*
  behavioural model of the loop generator register port.
  assumes one host request at a time and a device base of zero.
*/
`timescale 1ns/100ps
`default_nettype none
module pcc_dev_model (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        slow_in,
  input  wire logic        req_in,
  input  wire logic        we_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [31:0] wdata_in,
  output logic             ack_out,
  output logic [31:0]      rdata_out
);
  logic [31:0] mem [0:127];
  logic [2:0]  dly;
  logic [2:0]  busy;
  logic [6:0]  a;
  int          rst_cyc, lock_cyc, lock_en, wr_cnt, go_cnt, brg_cnt;
  assign a = addr_in[8:2];
  // parked read bus toggles, so stale data never passes for an answer
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      foreach (mem[i]) mem[i] <= 32'h0000_0000;
      mem[7'h44] <= 32'h0000_000C;
      mem[7'h45] <= 32'h0000_8000;
      mem[7'h46] <= 32'h0000_8000;
      mem[7'h47] <= 32'h0000_8001;
      mem[7'h48] <= 32'h0000_8002;
      {ack_out, dly, busy} <= '0;
      rdata_out <= 32'h0000_0000;
      {rst_cyc, lock_cyc, lock_en, wr_cnt, go_cnt, brg_cnt} <= '0;
    end else begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
      lock_cyc <= lock_cyc + 1;
      if (busy != 3'd0) busy <= busy - 3'd1;
      if (mem[7'h40][1]) rst_cyc <= rst_cyc + 1;
      if (req_in && !ack_out) begin
        dly <= dly + 3'd1;
        if (dly >= (slow_in ? 3'd3 : 3'd0)) begin
          ack_out <= 1'b1;
          dly <= 3'd0;
          rdata_out <= (a == 7'h4F) ? {31'h0, busy != 3'd0} : mem[a];
          if (we_in) begin
            mem[a] <= wdata_in;
            wr_cnt <= wr_cnt + 1;
            if (a == 7'h40 && wdata_in[1]) rst_cyc <= 0;
            if (a == 7'h40 && wdata_in[0]) lock_en <= lock_cyc;
            if (a == 7'h44 || a == 7'h45) lock_cyc <= 0;
            if (a == 7'h4E) begin
              busy <= 3'd5;
              go_cnt <= go_cnt + 1;
            end
            if (a == 7'h09 && wdata_in[0]) brg_cnt <= brg_cnt + 1;
          end
        end
      end
    end
  end
endmodule // pcc_dev_model
`default_nettype wire

// ---- testbench/tb.sv ----
/*
  self-checking bench for the loop host: axi4-lite master and device model.
  assumes the package constants and a shortened lock wait of 20 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clock_in = 1'b0, rst_in = 1'b1, slow = 1'b0;
  logic [4:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, dwd, drd, dad;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, dreq, dwe, dack;
  logic [1:0] bresp, rresp;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  pcc_loop_host #(.LOCK_CYCLES(20)) i_pcc_loop_host (.clock_in(clock_in),
    .rst_in(rst_in), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .dev_req_out(dreq), .dev_we_out(dwe),
    .dev_addr_out(dad), .dev_wdata_out(dwd), .dev_ack_in(dack),
    .dev_rdata_in(drd));
  pcc_dev_model i_pcc_dev_model (.clock_in(clock_in), .rst_in(rst_in),
    .slow_in(slow), .req_in(dreq), .we_in(dwe), .addr_in(dad),
    .wdata_in(dwd), .ack_out(dack), .rdata_out(drd));
  always #5 clock_in = ~clock_in;
  // hang guard, far above fifteen setups
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic axw(input logic [4:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    // bready stays high: lowering it here would collide with the next call
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic axr(input logic [4:0] a, output logic [31:0] d);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
  endtask
  function automatic logic ok(int r, m, a, b, c, d);
    return a > 0 && b > 0 && d > 0 && r >= 12000*a && r <= 50000*a &&
      m >= 4 && m <= 25 && r*m >= 140000*a && r*m <= 600000*a &&
      (c == 2*b || c == 3*b || c == 4*b);
  endfunction
  function automatic logic [31:0] dv(input int i);
    return i_pcc_dev_model.mem[i];
  endfunction
  // one setup: program, start, then compare device registers
  task automatic run(input int r, m, a, b, c, d, input logic [31:0] cmd);
    logic [31:0] st;
    int w0, g0, b0;
    logic v;
    v = ok(r, m, a, b, c, d);
    w0 = i_pcc_dev_model.wr_cnt; g0 = i_pcc_dev_model.go_cnt;
    b0 = i_pcc_dev_model.brg_cnt;
    axw(pcc_pkg::REG_REF, r, pcc_pkg::RESP_OKAY);
    axw(pcc_pkg::REG_MULT, m, pcc_pkg::RESP_OKAY);
    axw(pcc_pkg::REG_DIVS, {3'h0, d[4:0], 3'h0, c[4:0], 3'h0, b[4:0],
        3'h0, a[4:0]}, pcc_pkg::RESP_OKAY);
    axw(pcc_pkg::REG_CTRL, cmd, pcc_pkg::RESP_OKAY);
    // settings are frozen while a setup runs; this write must be ignored
    if (v) axw(pcc_pkg::REG_MULT, 32'h0, pcc_pkg::RESP_OKAY);
    do axr(pcc_pkg::REG_STAT, st); while (st[1] !== 1'b1 && st[2] !== 1'b1);
    chk({31'h0, st[2]}, {31'h0, !v});
    if (!v) chk(i_pcc_dev_model.wr_cnt, w0);
    else begin
      chk(dv(72), 32'h8000 | (d - 1));
      chk(dv(71), 32'h8000 | (c - 1));
      chk(dv(70), 32'h8000 | (b - 1));
      axr(pcc_pkg::REG_MULT, st);
      chk(st, m);
      chk(dv(80) & 32'h7, 32'h7);
      chk(i_pcc_dev_model.go_cnt, g0 + 1);
      chk(i_pcc_dev_model.brg_cnt, b0 + 1);
      chk(dv(9) & 32'h1, 32'h0);
      if (cmd == 1) begin
        chk(dv(68), m - 1);
        chk(dv(69), 32'h8000 | (a - 1));
        chk(dv(64), 32'h1);
        chk(i_pcc_dev_model.rst_cyc >= 13, 1);
        chk(i_pcc_dev_model.lock_en >= 20, 1);
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    int r, m, a, b;
    void'($urandom(52));
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    axr(pcc_pkg::REG_STAT, d);
    chk(d & 32'hF, 32'h0);
    chk(dv(68), 32'hC);
    chk(dv(71), 32'h8001);
    axr(pcc_pkg::REG_REF, d);
    chk(d, {12'h000, pcc_pkg::REF_RST});
    axr(5'h14, d);
    chk({30'h0, rresp}, {30'h0, pcc_pkg::RESP_SLVERR});
    chk(d, 32'h0);
    axw(5'h18, 32'h1, pcc_pkg::RESP_SLVERR);
    // byte lanes: only the pre-divider byte may change
    wstrb <= 4'h1;
    axw(pcc_pkg::REG_DIVS, 32'h1F1F_1F05, pcc_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    axr(pcc_pkg::REG_DIVS, d);
    chk(d, {3'h0, pcc_pkg::D3_RST, 3'h0, pcc_pkg::D2_RST,
            3'h0, pcc_pkg::D1_RST, 8'h05});
    run(12000, 12, 1, 1, 2, 1, 1);
    run(50000, 12, 1, 2, 8, 3, 1);
    run(24000, 26, 1, 1, 2, 3, 1);
    run(24000, 13, 1, 1, 5, 3, 1);
    run(24000, 13, 1, 2, 6, 4, 2);
    repeat (10) begin
      slow <= 1'($urandom_range(1));
      a = $urandom_range(2, 1); b = $urandom_range(4, 1);
      r = $urandom_range(60000 * a, 8000); m = $urandom_range(26, 3);
      run(r, m, a, b, b * $urandom_range(5, 1), $urandom_range(8, 1), 1);
    end
    // second reset after the last setup: settings fall back to their defaults
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    axr(pcc_pkg::REG_MULT, d);
    chk(d, {27'h000_0000, pcc_pkg::MULT_RST});
    end_of_test();
  end
endmodule // tb
`default_nettype wire
